//--- mmne_pkg.sv
// Package: opcodes, field layouts, register map for the move/multiply/negate executor
package mmne_pkg;
  localparam int unsigned DATA_W = 32;

  // Operation codes on the command port
  localparam logic [4:0] OP_BYTE_LOAD   = 5'h00;
  localparam logic [4:0] OP_BYTE_STORE  = 5'h01;
  localparam logic [4:0] OP_BYTE_COPY   = 5'h02;
  localparam logic [4:0] OP_REG_MOVE    = 5'h03;
  localparam logic [4:0] OP_FIELD_STORE = 5'h04;
  localparam logic [4:0] OP_FIELD_LOAD  = 5'h05;
  localparam logic [4:0] OP_FIELD_COPY  = 5'h06;
  localparam logic [4:0] OP_IMM_SHORT   = 5'h07;
  localparam logic [4:0] OP_IMM_LONG    = 5'h08;
  localparam logic [4:0] OP_CONST_LOAD  = 5'h09;
  localparam logic [4:0] OP_LOW_HALF    = 5'h0a;
  localparam logic [4:0] OP_HIGH_HALF   = 5'h0b;
  localparam logic [4:0] OP_MUL_SIGNED  = 5'h0c;
  localparam logic [4:0] OP_MUL_UNSIGN  = 5'h0d;
  localparam logic [4:0] OP_NEGATE      = 5'h0e;
  localparam logic [4:0] OP_NEG_BORROW  = 5'h0f;

  // Addressing modes for source and destination
  localparam logic [2:0] AM_REG    = 3'h0;
  localparam logic [2:0] AM_IND    = 3'h1;
  localparam logic [2:0] AM_OFFSET = 3'h2;
  localparam logic [2:0] AM_POSTINC = 3'h3;
  localparam logic [2:0] AM_PREDEC = 3'h4;
  localparam logic [2:0] AM_ABS    = 3'h5;

  // Byte access width in bits
  localparam logic [5:0] BYTE_SIZE = 6'h08;

  // Register map (byte addresses)
  localparam logic [7:0] REG_CMD    = 8'h00;
  localparam logic [7:0] REG_REGSEL = 8'h04;
  localparam logic [7:0] REG_SRCOP  = 8'h08;
  localparam logic [7:0] REG_DSTOP  = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_GPR    = 8'h40;

  // Command register fields
  localparam int CMD_OP_LSB   = 0;
  localparam int CMD_SAM_LSB  = 8;
  localparam int CMD_DAM_LSB  = 12;
  localparam int CMD_FSEL_BIT = 16;
  localparam int CMD_GO_BIT   = 31;

  // Status word fields
  localparam int ST_FS0_LSB = 0;
  localparam int ST_FE0_BIT = 5;
  localparam int ST_FS1_LSB = 6;
  localparam int ST_FE1_BIT = 11;
  localparam int ST_BUSY_BIT = 15;
  localparam int ST_V_BIT   = 28;
  localparam int ST_Z_BIT   = 29;
  localparam int ST_C_BIT   = 30;
  localparam int ST_N_BIT   = 31;
  localparam logic [31:0] ST_RESET = 32'h0000_0000;

  typedef enum logic [4:0] {
    MMNE_IDLE  = 5'b00001,
    MMNE_ADDR  = 5'b00010,
    MMNE_READ  = 5'b00100,
    MMNE_WRITE = 5'b01000,
    MMNE_DONE  = 5'b10000
  } mmne_state_e;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [31:0] addr;
    logic [5:0]  size;
    logic [31:0] wdata;
  } mmne_mem_req_s;

  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
  } mmne_mem_rsp_s;
endpackage

//--- mmne_core.sv
// Executor for byte/field moves, loads, half moves, multiply and negate
// Notes on behaviour
// - Loaded byte sign-extends from bit seven
// - Indirect byte copy reads source, writes destination
// - Offset forms add offset to register
// - Absolute forms use instruction addresses directly
// - Register move copies whole word, any file
// - Field store writes source low bits
// - Postincrement adds field size after field transfers; byte forms leave the register unchanged
// - Predecrement subtracts access size (eight for byte forms, else field size) before transfer
// - Field copy postincrement advances both address registers
// - Copy predecrement reduces both registers first
// - Field load reads field into destination
// - Offset source, postincrement destination advances destination
// - Absolute source, postincrement destination advances destination
// - Short immediate sign-extends, long loads unchanged
// - Constant load zero-extends, flags untouched
// - Low half move keeps destination upper
// - High half move keeps destination lower
// - Signed multiply, even destination gives pair
// - Unsigned multiply, same pairing unsigned
// - Negate stores two's complement
// - Negate with borrow subtracts carry
// - Field select picks first or second setting
//
// The address map and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
module mmne_core #(
  parameter int NREGS = 32
) (
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic [7:0]             s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [7:0]             s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  output mmne_pkg::mmne_mem_req_s     mem_req,
  input  wire mmne_pkg::mmne_mem_rsp_s mem_rsp
);
  localparam int RW = $clog2(NREGS);

  typedef struct packed {
    logic                 aw_ok;
    logic                 w_ok;
    logic [7:0]           awaddr;
    logic [31:0]          wdata;
    logic [3:0]           wstrb;
    logic                 bvalid;
    logic [1:0]           bresp;
    logic                 rvalid;
    logic [1:0]           rresp;
    logic [31:0]          rdata;
    logic [31:0]          cmd;
    logic [31:0]          regsel;
    logic [31:0]          srcop;
    logic [31:0]          dstop;
    logic [31:0]          status_word;
    logic [NREGS*32-1:0]  gpr;
    mmne_pkg::mmne_state_e state;
    logic [31:0]          saddr;
    logic [31:0]          daddr;
    logic [31:0]          data;
    mmne_pkg::mmne_mem_req_s mreq;
  } mmne_s;

  mmne_s q_r;
  mmne_s q_nxt;

  logic [4:0]  op;
  logic [2:0]  sam;
  logic [2:0]  dam;
  logic [RW-1:0] rs_idx;
  logic [RW-1:0] rd_idx;
  logic [RW-1:0] rd_pair;
  logic [31:0] rs_v;
  logic [31:0] rd_v;
  logic [5:0]  fsz_raw;
  logic [5:0]  fsize;
  logic        fext;
  logic        is_byte;
  logic [5:0]  xsize;
  logic        xext;
  logic [63:0] prod;
  logic [31:0] mul_src;
  logic [31:0] fmask;
  logic [31:0] ext_data;
  logic [31:0] neg_v;
  logic        wr_go;
  logic        reg_hit;

  assign op      = q_r.cmd[mmne_pkg::CMD_OP_LSB +: 5];
  assign sam     = q_r.cmd[mmne_pkg::CMD_SAM_LSB +: 3];
  assign dam     = q_r.cmd[mmne_pkg::CMD_DAM_LSB +: 3];
  assign rs_idx  = q_r.regsel[RW-1:0];
  assign rd_idx  = q_r.regsel[8 +: RW];
  assign rd_pair = rd_idx + RW'(1);
  assign rs_v    = q_r.gpr[rs_idx*32 +: 32];
  assign rd_v    = q_r.gpr[rd_idx*32 +: 32];

  always_comb begin
    if (q_r.cmd[mmne_pkg::CMD_FSEL_BIT]) begin
      fsz_raw = {1'b0, q_r.status_word[mmne_pkg::ST_FS1_LSB +: 5]};
      fext    = q_r.status_word[mmne_pkg::ST_FE1_BIT];
    end else begin
      fsz_raw = {1'b0, q_r.status_word[mmne_pkg::ST_FS0_LSB +: 5]};
      fext    = q_r.status_word[mmne_pkg::ST_FE0_BIT];
    end
  end
  // Size code zero means a full 32-bit field
  assign fsize   = (fsz_raw[4:0] == 5'h00) ? 6'h20 : {1'b0, fsz_raw[4:0]};
  assign is_byte = (op == mmne_pkg::OP_BYTE_LOAD) || (op == mmne_pkg::OP_BYTE_STORE) ||
                   (op == mmne_pkg::OP_BYTE_COPY);
  assign xsize   = is_byte ? mmne_pkg::BYTE_SIZE : fsize;
  assign xext    = is_byte ? 1'b1 : fext;
  assign fmask   = (xsize == 6'h20) ? 32'hffff_ffff : ((32'h0000_0001 << xsize[4:0]) - 32'h0000_0001);

  // zero or sign extension of loaded field
  always_comb begin
    ext_data = q_r.data & fmask;
    if (xext && xsize != 6'h20 && q_r.data[xsize[4:0] - 5'h01]) begin
      ext_data = ext_data | ~fmask;
    end
  end

  // signed or unsigned product of source field and destination
  always_comb begin
    mul_src = rs_v & (fsize == 6'h20 ? 32'hffff_ffff : ((32'h0000_0001 << fsize[4:0]) - 32'h0000_0001));
    if (op == mmne_pkg::OP_MUL_SIGNED) begin
      if (fsize != 6'h20 && rs_v[fsize[4:0] - 5'h01]) begin
        mul_src = mul_src | ~((32'h0000_0001 << fsize[4:0]) - 32'h0000_0001);
      end
      prod = {{32{mul_src[31]}}, mul_src} * {{32{rd_v[31]}}, rd_v};
    end else begin
      prod = {32'h0000_0000, mul_src} * {32'h0000_0000, rd_v};
    end
  end

  // extra one subtracted when carry set
  assign neg_v = (32'h0000_0000 - rd_v) -
                 ((op == mmne_pkg::OP_NEG_BORROW && q_r.status_word[mmne_pkg::ST_C_BIT]) ? 32'h1 : 32'h0);

  assign wr_go   = q_r.aw_ok && q_r.w_ok && !q_r.bvalid;
  assign reg_hit = q_r.awaddr >= mmne_pkg::REG_GPR &&
                   q_r.awaddr < 8'(mmne_pkg::REG_GPR + 8'(NREGS * 4));

  always_comb begin
    logic [RW-1:0] gi;
    logic [31:0]   rdv;
    logic [31:0]   nv;
    q_nxt = q_r;
    gi  = '0;
    rdv = 32'h0000_0000;
    nv  = 32'h0000_0000;
    q_nxt.mreq.req = 1'b0;

    // Write channels, taken in either order
    if (s_axi_awvalid && !q_r.aw_ok) begin
      q_nxt.aw_ok  = 1'b1;
      q_nxt.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !q_r.w_ok) begin
      q_nxt.w_ok  = 1'b1;
      q_nxt.wdata = s_axi_wdata;
      q_nxt.wstrb = s_axi_wstrb;
    end
    if (wr_go) begin
      q_nxt.aw_ok  = 1'b0;
      q_nxt.w_ok   = 1'b0;
      q_nxt.bvalid = 1'b1;
      q_nxt.bresp  = 2'b00;
      // Registers are only writable while idle; busy writes are slave errors
      if (q_r.state != mmne_pkg::MMNE_IDLE) begin
        q_nxt.bresp = 2'b10;
      end else begin
        case (q_r.awaddr)
          mmne_pkg::REG_CMD:    q_nxt.cmd = q_r.wdata;
          mmne_pkg::REG_REGSEL: q_nxt.regsel = q_r.wdata;
          mmne_pkg::REG_SRCOP:  q_nxt.srcop = q_r.wdata;
          mmne_pkg::REG_DSTOP:  q_nxt.dstop = q_r.wdata;
          mmne_pkg::REG_STATUS: q_nxt.status_word = q_r.wdata;
          default: begin
            if (reg_hit) begin
              gi = RW'((q_r.awaddr - mmne_pkg::REG_GPR) >> 2);
              q_nxt.gpr[gi*32 +: 32] = q_r.wdata;
            end else begin
              q_nxt.bresp = 2'b10;
            end
          end
        endcase
      end
    end
    if (q_r.bvalid && s_axi_bready) begin
      q_nxt.bvalid = 1'b0;
    end

    // Read channel
    if (s_axi_arvalid && !q_r.rvalid) begin
      q_nxt.rvalid = 1'b1;
      q_nxt.rresp  = 2'b00;
      case (s_axi_araddr)
        mmne_pkg::REG_CMD:    rdv = q_r.cmd;
        mmne_pkg::REG_REGSEL: rdv = q_r.regsel;
        mmne_pkg::REG_SRCOP:  rdv = q_r.srcop;
        mmne_pkg::REG_DSTOP:  rdv = q_r.dstop;
        mmne_pkg::REG_STATUS: begin
          rdv = q_r.status_word;
          rdv[mmne_pkg::ST_BUSY_BIT] = (q_r.state != mmne_pkg::MMNE_IDLE);
        end
        default: begin
          if (s_axi_araddr >= mmne_pkg::REG_GPR &&
              s_axi_araddr < 8'(mmne_pkg::REG_GPR + 8'(NREGS * 4))) begin
            gi  = RW'((s_axi_araddr - mmne_pkg::REG_GPR) >> 2);
            rdv = q_r.gpr[gi*32 +: 32];
          end else begin
            q_nxt.rresp = 2'b10;
          end
        end
      endcase
      q_nxt.rdata = rdv;
    end else if (q_r.rvalid && s_axi_rready) begin
      q_nxt.rvalid = 1'b0;
    end

    case (q_r.state)
      mmne_pkg::MMNE_IDLE: begin
        if (q_r.cmd[mmne_pkg::CMD_GO_BIT]) begin
          q_nxt.cmd[mmne_pkg::CMD_GO_BIT] = 1'b0;
          q_nxt.state = mmne_pkg::MMNE_ADDR;
        end
      end
      mmne_pkg::MMNE_ADDR: begin
        q_nxt.state = mmne_pkg::MMNE_DONE;
        case (sam)
          mmne_pkg::AM_OFFSET: q_nxt.saddr = rs_v + q_r.srcop;
          mmne_pkg::AM_ABS:    q_nxt.saddr = q_r.srcop;
          mmne_pkg::AM_PREDEC: begin
            q_nxt.saddr = rs_v - 32'(xsize);
            q_nxt.gpr[rs_idx*32 +: 32] = rs_v - 32'(xsize);
          end
          default: q_nxt.saddr = rs_v;
        endcase
        case (dam)
          mmne_pkg::AM_OFFSET: q_nxt.daddr = rd_v + q_r.dstop;
          mmne_pkg::AM_ABS:    q_nxt.daddr = q_r.dstop;
          mmne_pkg::AM_PREDEC: begin
            q_nxt.daddr = rd_v - 32'(xsize);
            q_nxt.gpr[rd_idx*32 +: 32] = rd_v - 32'(xsize);
          end
          default: q_nxt.daddr = rd_v;
        endcase
        case (op)
          mmne_pkg::OP_BYTE_LOAD, mmne_pkg::OP_BYTE_COPY,
          mmne_pkg::OP_FIELD_LOAD, mmne_pkg::OP_FIELD_COPY:
            q_nxt.state = mmne_pkg::MMNE_READ;
          // source low bits go to memory
          mmne_pkg::OP_BYTE_STORE, mmne_pkg::OP_FIELD_STORE: begin
            q_nxt.data  = rs_v & fmask;
            q_nxt.state = mmne_pkg::MMNE_WRITE;
          end
          mmne_pkg::OP_REG_MOVE: q_nxt.gpr[rd_idx*32 +: 32] = rs_v;
          mmne_pkg::OP_IMM_SHORT: begin
            nv = {{16{q_r.srcop[15]}}, q_r.srcop[15:0]};
            q_nxt.gpr[rd_idx*32 +: 32] = nv;
          end
          mmne_pkg::OP_IMM_LONG: q_nxt.gpr[rd_idx*32 +: 32] = q_r.srcop;
          mmne_pkg::OP_CONST_LOAD: q_nxt.gpr[rd_idx*32 +: 32] = {27'h0, q_r.srcop[4:0]};
          mmne_pkg::OP_LOW_HALF: q_nxt.gpr[rd_idx*32 +: 32] = {rd_v[31:16], rs_v[15:0]};
          mmne_pkg::OP_HIGH_HALF: q_nxt.gpr[rd_idx*32 +: 32] = {rs_v[31:16], rd_v[15:0]};
          mmne_pkg::OP_MUL_SIGNED, mmne_pkg::OP_MUL_UNSIGN: begin
            if (!rd_idx[0]) begin
              q_nxt.gpr[rd_idx*32 +: 32]  = prod[63:32];
              q_nxt.gpr[rd_pair*32 +: 32] = prod[31:0];
            end else begin
              q_nxt.gpr[rd_idx*32 +: 32] = prod[31:0];
            end
            q_nxt.status_word[mmne_pkg::ST_N_BIT] = prod[63];
            q_nxt.status_word[mmne_pkg::ST_Z_BIT] = (prod == 64'h0);
          end
          mmne_pkg::OP_NEGATE, mmne_pkg::OP_NEG_BORROW: begin
            q_nxt.gpr[rd_idx*32 +: 32] = neg_v;
            q_nxt.status_word[mmne_pkg::ST_N_BIT] = neg_v[31];
            q_nxt.status_word[mmne_pkg::ST_Z_BIT] = (neg_v == 32'h0);
            q_nxt.status_word[mmne_pkg::ST_C_BIT] = (rd_v != 32'h0) || neg_v[31];
            q_nxt.status_word[mmne_pkg::ST_V_BIT] = (rd_v == 32'h8000_0000);
          end
          default: q_nxt.state = mmne_pkg::MMNE_DONE;
        endcase
      end
      mmne_pkg::MMNE_READ: begin
        q_nxt.mreq = '{req: 1'b1, we: 1'b0, addr: q_r.saddr, size: xsize, wdata: 32'h0};
        if (q_r.mreq.req && mem_rsp.ack) begin
          q_nxt.mreq.req = 1'b0;
          q_nxt.data = mem_rsp.rdata;
          if (op == mmne_pkg::OP_BYTE_COPY || op == mmne_pkg::OP_FIELD_COPY) begin
            q_nxt.state = mmne_pkg::MMNE_WRITE;
          end else begin
            q_nxt.state = mmne_pkg::MMNE_DONE;
          end
        end
      end
      mmne_pkg::MMNE_WRITE: begin
        q_nxt.mreq = '{req: 1'b1, we: 1'b1, addr: q_r.daddr, size: xsize, wdata: q_r.data & fmask};
        if (q_r.mreq.req && mem_rsp.ack) begin
          q_nxt.mreq.req = 1'b0;
          q_nxt.state = mmne_pkg::MMNE_DONE;
        end
      end
      mmne_pkg::MMNE_DONE: begin
        q_nxt.state = mmne_pkg::MMNE_IDLE;
        if (op == mmne_pkg::OP_BYTE_LOAD || op == mmne_pkg::OP_FIELD_LOAD) begin
          q_nxt.gpr[rd_idx*32 +: 32] = ext_data;
        end
        if (!is_byte && sam == mmne_pkg::AM_POSTINC &&
            (op == mmne_pkg::OP_FIELD_LOAD || op == mmne_pkg::OP_FIELD_COPY)) begin
          q_nxt.gpr[rs_idx*32 +: 32] = rs_v + 32'(fsize);
        end
        if (!is_byte && dam == mmne_pkg::AM_POSTINC &&
            (op == mmne_pkg::OP_FIELD_STORE || op == mmne_pkg::OP_FIELD_COPY)) begin
          q_nxt.gpr[rd_idx*32 +: 32] = rd_v + 32'(fsize);
        end
      end
      default: q_nxt.state = mmne_pkg::MMNE_IDLE;
    endcase

    if (!aresetn) begin
      q_nxt = '0;
      q_nxt.state = mmne_pkg::MMNE_IDLE;
      q_nxt.status_word = mmne_pkg::ST_RESET;
    end
  end

  always_ff @(posedge aclk) begin
    q_r <= q_nxt;
  end

  assign s_axi_awready = !q_r.aw_ok;
  assign s_axi_wready  = !q_r.w_ok;
  assign s_axi_bvalid  = q_r.bvalid;
  assign s_axi_bresp   = q_r.bresp;
  assign s_axi_arready = !q_r.rvalid;
  assign s_axi_rvalid  = q_r.rvalid;
  assign s_axi_rdata   = q_r.rdata;
  assign s_axi_rresp   = q_r.rresp;
  assign mem_req       = q_r.mreq;
endmodule

//--- mmne_core_checker.sv
// Bus and memory port checker for the executor
`timescale 1ns/1ps
module mmne_core_checker (
  input wire logic                    aclk,
  input wire logic                    aresetn,
  input wire logic                    s_axi_awvalid,
  input wire logic                    s_axi_awready,
  input wire logic                    s_axi_wvalid,
  input wire logic                    s_axi_wready,
  input wire logic [1:0]              s_axi_bresp,
  input wire logic                    s_axi_bvalid,
  input wire logic                    s_axi_bready,
  input wire logic                    s_axi_arvalid,
  input wire logic                    s_axi_arready,
  input wire logic [31:0]             s_axi_rdata,
  input wire logic                    s_axi_rvalid,
  input wire logic                    s_axi_rready,
  input wire mmne_pkg::mmne_mem_req_s mem_req,
  input wire mmne_pkg::mmne_mem_rsp_s mem_rsp
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late or early");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data not one cycle after address");
  a_resp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before accepted");
  a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed before accepted");
  a_read_block: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data still shown after accepted");
  a_aw_held: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("write address ready while previous write held");
  // Request must not wander while the memory stalls
  a_mem_hold: assert property (mem_req.req && !mem_rsp.ack |=> mem_req.req && $stable(mem_req))
    else $error("memory request changed before acknowledge");
  a_mem_release: assert property (mem_req.req && mem_rsp.ack |=> !mem_req.req)
    else $error("memory request not released after acknowledge");
endmodule

bind mmne_core mmne_core_checker u_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .mem_req(mem_req), .mem_rsp(mem_rsp)
);

//--- mmne_mem_model.sv
// Memory partner with random wait states
`timescale 1ns/1ps
module mmne_mem_model (
  input  wire logic                    aclk,
  input  wire mmne_pkg::mmne_mem_req_s mem_req,
  output mmne_pkg::mmne_mem_rsp_s      mem_rsp
);
  logic [31:0] mem [logic [31:0]];
  logic [31:0] wr_addr = 32'h0;
  logic [31:0] wr_data = 32'h0;
  logic [5:0]  wr_size = 6'h00;
  int          wait_n = 0;
  initial mem_rsp = '0;
  always @(posedge aclk) begin
    mem_rsp.ack <= 1'b0;
    // Stale data toggles so a late sample cannot pass
    mem_rsp.rdata <= ~mem_rsp.rdata;
    if (mem_req.req && !mem_rsp.ack) begin
      if (wait_n > 0) begin
        wait_n <= wait_n - 1;
      end else begin
        mem_rsp.ack <= 1'b1;
        wait_n <= $urandom_range(0, 3);
        if (mem_req.we) begin
          mem[mem_req.addr] = mem_req.wdata;
          wr_addr <= mem_req.addr;
          wr_data <= mem_req.wdata;
          wr_size <= mem_req.size;
        end else begin
          mem_rsp.rdata <= mem.exists(mem_req.addr) ? mem[mem_req.addr] : ~mem_req.addr;
        end
      end
    end
  end
endmodule

//--- test_move_multiply_negate_execute.sv
// Self-checking bench for the move, multiply and negate executor
`timescale 1ns/1ps
module test_move_multiply_negate_execute;
  localparam logic [31:0] STS = 32'h0000_0b10;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, sel, a, b, g, rdata;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, r;
  logic [63:0] p;
  int          n_errors = 0, total_checks = 0;
  mmne_pkg::mmne_mem_req_s mem_req;
  mmne_pkg::mmne_mem_rsp_s mem_rsp;

  mmne_core #(.NREGS(32)) u_mmne_core (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .mem_req(mem_req), .mem_rsp(mem_rsp));
  mmne_mem_model u_mem (.aclk(aclk), .mem_req(mem_req), .mem_rsp(mem_rsp));

  initial forever #4 aclk = ~aclk;

  task automatic tally_and_finish();
    $display("Checks %0d, errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    total_checks++;
    if (s !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic hang();
    n_errors++;
    $display("[FAIL] handshake expected in bound seen timeout");
    tally_and_finish();
  endtask
  // Ready raised late on purpose to exercise the hold rules
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    int i;
    @(posedge aclk);
    awaddr <= ad;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (i = 0; i < 60; i++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid && bready) break;
      if (bvalid) bready <= 1'b1;
    end
    chk("write resp", 32'h0, {30'h0, bresp});
    bready <= 1'b0;
    if (i == 60) hang();
  endtask
  task automatic rd(input logic [7:0] ad, output logic [31:0] d, output logic [1:0] rr);
    int i;
    @(posedge aclk);
    araddr <= ad;
    arvalid <= 1'b1;
    for (i = 0; i < 60; i++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid && rready) break;
      if (rvalid) rready <= 1'b1;
    end
    d = rdata;
    rr = rresp;
    rready <= 1'b0;
    if (i == 60) hang();
  endtask
  task automatic setr(input int i, input logic [31:0] v);
    wr(mmne_pkg::REG_GPR + 8'(4 * i), v);
  endtask
  task automatic getr(input int i, output logic [31:0] v);
    rd(mmne_pkg::REG_GPR + 8'(4 * i), v, r);
  endtask
  task automatic go(input logic [4:0] op, input logic [2:0] sm, dm, input logic f, input logic [31:0] so, dp);
    logic [31:0] s;
    int i;
    wr(mmne_pkg::REG_REGSEL, sel);
    wr(mmne_pkg::REG_SRCOP, so);
    wr(mmne_pkg::REG_DSTOP, dp);
    wr(mmne_pkg::REG_CMD, {1'b1, 14'h0, f, 1'b0, dm, 1'b0, sm, 3'h0, op});
    for (i = 0; i < 40; i++) begin
      rd(mmne_pkg::REG_STATUS, s, r);
      if (s[mmne_pkg::ST_BUSY_BIT] === 1'b0) break;
    end
    if (i == 40) hang();
  endtask
  function automatic logic [31:0] ext(input logic [31:0] v, input int sz, input logic sx);
    logic [31:0] mk = (sz >= 32) ? 32'hffff_ffff : ((32'h1 << sz) - 32'h1);
    return (sx && v[sz-1]) ? (v | ~mk) : (v & mk);
  endfunction
  // Pointer value that makes mode m reach address t
  function automatic void place(input logic [2:0] m, input logic [31:0] t, input int sz,
                                output logic [31:0] rv, output logic [31:0] o);
    o = 32'($urandom_range(1, 255));
    rv = $urandom;
    case (m)
      mmne_pkg::AM_OFFSET: rv = t - o;
      mmne_pkg::AM_ABS: o = t;
      mmne_pkg::AM_PREDEC: rv = t + 32'(sz);
      default: rv = t;
    endcase
  endfunction
  task automatic mv(input logic [4:0] op, input logic [2:0] sm, dm, input logic f, input int sz, input logic sx);
    logic [31:0] sa, da, v, rs, rdv, so, dp;
    sa = 32'h0010_0000 + ($urandom & 32'h000f_fff0);
    da = sa + 32'h0040_0000;
    v = $urandom;
    u_mem.mem[sa] = v;
    so = 32'h0;
    dp = 32'h0;
    rs = v;
    rdv = $urandom;
    if (sm != mmne_pkg::AM_REG) place(sm, sa, sz, rs, so);
    if (dm != mmne_pkg::AM_REG) place(dm, da, sz, rdv, dp);
    setr(1, rs);
    setr(2, rdv);
    go(op, sm, dm, f, so, dp);
    getr(2, g);
    if (dm == mmne_pkg::AM_REG) begin
      chk("loaded value", ext(v, sz, sx), g);
    end else begin
      chk("write address", da, u_mem.wr_addr);
      chk("write data", ext(v, sz, 1'b0), ext(u_mem.wr_data, sz, 1'b0));
      chk("write size", 32'(sz), {26'h0, u_mem.wr_size});
      chk("dest pointer", dm == mmne_pkg::AM_POSTINC ? da + sz : (dm == mmne_pkg::AM_PREDEC ? da : rdv), g);
    end
    getr(1, g);
    if (sm != mmne_pkg::AM_REG)
      chk("src pointer", sm == mmne_pkg::AM_POSTINC ? sa + sz : (sm == mmne_pkg::AM_PREDEC ? sa : rs), g);
  endtask
  task automatic one(input logic [4:0] op, input logic [31:0] so);
    setr(1, a);
    setr(2, b);
    go(op, mmne_pkg::AM_REG, mmne_pkg::AM_REG, 1'b0, so, 32'h0);
    getr(2, g);
  endtask

  initial begin
    void'($urandom(12));
    sel = 32'h0000_0201;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd(mmne_pkg::REG_STATUS, g, r);
    chk("status at reset", mmne_pkg::ST_RESET, g);
    rd(8'h20, g, r);
    chk("unmapped resp", 32'h2, {30'h0, r});
    wr(mmne_pkg::REG_STATUS, STS);
    mv(mmne_pkg::OP_BYTE_LOAD, mmne_pkg::AM_IND, mmne_pkg::AM_REG, 1'b0, 8, 1'b1);
    mv(mmne_pkg::OP_BYTE_LOAD, mmne_pkg::AM_ABS, mmne_pkg::AM_REG, 1'b0, 8, 1'b1);
    mv(mmne_pkg::OP_BYTE_COPY, mmne_pkg::AM_IND, mmne_pkg::AM_IND, 1'b0, 8, 1'b1);
    mv(mmne_pkg::OP_BYTE_COPY, mmne_pkg::AM_OFFSET, mmne_pkg::AM_OFFSET, 1'b0, 8, 1'b1);
    mv(mmne_pkg::OP_BYTE_COPY, mmne_pkg::AM_ABS, mmne_pkg::AM_ABS, 1'b0, 8, 1'b1);
    mv(mmne_pkg::OP_BYTE_STORE, mmne_pkg::AM_REG, mmne_pkg::AM_OFFSET, 1'b0, 8, 1'b1);
    mv(mmne_pkg::OP_FIELD_STORE, mmne_pkg::AM_REG, mmne_pkg::AM_POSTINC, 1'b1, 12, 1'b1);
    mv(mmne_pkg::OP_FIELD_STORE, mmne_pkg::AM_REG, mmne_pkg::AM_PREDEC, 1'b0, 16, 1'b0);
    mv(mmne_pkg::OP_FIELD_COPY, mmne_pkg::AM_POSTINC, mmne_pkg::AM_POSTINC, 1'b0, 16, 1'b0);
    mv(mmne_pkg::OP_FIELD_COPY, mmne_pkg::AM_PREDEC, mmne_pkg::AM_PREDEC, 1'b1, 12, 1'b1);
    mv(mmne_pkg::OP_FIELD_LOAD, mmne_pkg::AM_IND, mmne_pkg::AM_REG, 1'b0, 16, 1'b0);
    mv(mmne_pkg::OP_FIELD_LOAD, mmne_pkg::AM_IND, mmne_pkg::AM_REG, 1'b1, 12, 1'b1);
    mv(mmne_pkg::OP_FIELD_COPY, mmne_pkg::AM_OFFSET, mmne_pkg::AM_POSTINC, 1'b0, 16, 1'b0);
    mv(mmne_pkg::OP_FIELD_COPY, mmne_pkg::AM_ABS, mmne_pkg::AM_POSTINC, 1'b1, 12, 1'b1);
    a = $urandom;
    b = $urandom;
    sel = 32'h0000_1401;
    one(mmne_pkg::OP_REG_MOVE, 32'h0);
    getr(20, g);
    chk("register move", a, g);
    sel = 32'h0000_0201;
    one(mmne_pkg::OP_IMM_SHORT, a | 32'h8000);
    chk("short immediate", {16'hffff, a[15:0] | 16'h8000}, g);
    one(mmne_pkg::OP_IMM_LONG, a);
    chk("long immediate", a, g);
    wr(mmne_pkg::REG_STATUS, STS | 32'hc000_0000);
    one(mmne_pkg::OP_CONST_LOAD, b);
    chk("constant", {27'h0, b[4:0]}, g);
    rd(mmne_pkg::REG_STATUS, g, r);
    chk("flags kept", STS | 32'hc000_0000, g);
    one(mmne_pkg::OP_LOW_HALF, 32'h0);
    chk("low half", {b[31:16], a[15:0]}, g);
    one(mmne_pkg::OP_HIGH_HALF, 32'h0);
    chk("high half", {a[31:16], b[15:0]}, g);
    // Field size zero means a full word source
    wr(mmne_pkg::REG_STATUS, 32'h0000_0b00);
    one(mmne_pkg::OP_MUL_SIGNED, 32'h0);
    p = {{32{a[31]}}, a} * {{32{b[31]}}, b};
    chk("signed high", p[63:32], g);
    getr(3, g);
    chk("signed low", p[31:0], g);
    one(mmne_pkg::OP_MUL_UNSIGN, 32'h0);
    p = {32'h0, a} * {32'h0, b};
    chk("unsigned high", p[63:32], g);
    getr(3, g);
    chk("unsigned low", p[31:0], g);
    one(mmne_pkg::OP_NEGATE, 32'h0);
    chk("negate", -b, g);
    wr(mmne_pkg::REG_STATUS, STS);
    one(mmne_pkg::OP_NEG_BORROW, 32'h0);
    chk("borrow clear", -b, g);
    wr(mmne_pkg::REG_STATUS, STS | 32'h4000_0000);
    one(mmne_pkg::OP_NEG_BORROW, 32'h0);
    chk("borrow set", -b - 32'h1, g);
    tally_and_finish();
  end
endmodule
